// ===== rtl/sfc_defines.vh
`ifndef SFC_DEFINES_VH
`define SFC_DEFINES_VH

// ----------------------------------------------------------------
// command opcodes
// ----------------------------------------------------------------
`define SFC_OP_WRITE_ENABLE     8'h06
`define SFC_OP_WRITE_DISABLE    8'h04
`define SFC_OP_STATUS_READ      8'h05
`define SFC_OP_STATUS_ARM       8'h50
`define SFC_OP_STATUS_WRITE     8'h01
`define SFC_OP_SECTOR_ERASE     8'h20
`define SFC_OP_BLOCK32_ERASE    8'h52
`define SFC_OP_BLOCK64_ERASE    8'hD8
`define SFC_OP_CHIP_ERASE_A     8'h60
`define SFC_OP_CHIP_ERASE_B     8'hC7
`define SFC_OP_JEDEC_ID         8'h9F
`define SFC_OP_LEGACY_ID_A      8'h90
`define SFC_OP_LEGACY_ID_B      8'hAB

// ----------------------------------------------------------------
// frame lengths in serial clock edges
// ----------------------------------------------------------------
`define SFC_LEN_OPCODE          6'd8
`define SFC_LEN_STATUS_WRITE    6'd16
`define SFC_LEN_ADDRESS         6'd32
`define SFC_LEN_WRAP_TOP        6'd47
`define SFC_LEN_WRAP_BACK       6'd32

// ----------------------------------------------------------------
// status byte field positions
// ----------------------------------------------------------------
`define SFC_ST_BUSY             0
`define SFC_ST_WRITE_LATCH      1
`define SFC_ST_LEVEL_LO         2
`define SFC_ST_AUTO_INC         6
`define SFC_ST_LOCK             7

// ----------------------------------------------------------------
// erase kinds and region size exponents (bytes = 1 << n)
// ----------------------------------------------------------------
`define SFC_KIND_SECTOR         2'h0
`define SFC_KIND_BLOCK32        2'h1
`define SFC_KIND_BLOCK64        2'h2
`define SFC_KIND_CHIP           2'h3
`define SFC_SECTOR_SHIFT        5'd12
`define SFC_BLOCK32_SHIFT       5'd15
`define SFC_BLOCK64_SHIFT       5'd16

// ----------------------------------------------------------------
// timing: clock rate and self-timed erase durations
// ----------------------------------------------------------------
`define SFC_CLK_KHZ             40000
`define SFC_SECTOR_ERASE_TIME_US 25000
`define SFC_BLOCK_ERASE_TIME_US  25000
`define SFC_CHIP_ERASE_TIME_US   50000
`define SFC_US_TO_CYCLES(t)     (((t) * `SFC_CLK_KHZ) / 1000)

// ----------------------------------------------------------------
// identification bytes (values arbitrary)
// ----------------------------------------------------------------
`define SFC_ID_MAKER            8'h5A
`define SFC_ID_TYPE             8'h3C
`define SFC_ID_CAPACITY         8'h17

`endif

// ===== rtl/sfc_cmd.v
`timescale 1ns/1ps
`default_nettype none
`include "sfc_defines.vh"

// Function
// R1 - sector erase clears addressed 4K sector
// R2 - host sends 20H then 24-bit address
// R3 - protected sector or block erase is dropped
// R4 - 52H erases 32K block above bit 15
// R5 - D8H erases 64K block above bit 16
// R6 - 60H or C7H erases whole array
// R7 - chip erase ignored if anything protected
// R8 - program or erase needs write latch set
// R9 - host keeps select low through command
// R10 - commands execute on select rising edge
// R11 - busy bit held during self-timed erase
// R12 - status readable anytime, repeats until deselect
// R13 - write enable sets write latch
// R14 - status write clears used write latch
// R15 - write disable clears latch and auto-increment
// R16 - write disable leaves running operation alone
// R17 - arm command must directly precede status write; code also accepts a set write latch instead
// R18 - status write changes level and lock bits
// R19 - status write ignored when locked, pin low
// R20 - pin low: lock bit only rises
// R21 - pin high: all protect bits writable
// R22 - 9FH returns maker, type, capacity bytes
// R23 - 90H/ABH with address returns ident bytes
// R24 - ident bytes alternate until deselect
// R25 - write disable 04H, status read 05H
// R26 - write enable 06H, arm 50H, write 01H
module sfc_cmd #(
    parameter ARRAY_AW       = 24,
    parameter CNT_W          = 32,
    parameter SECTOR_CYCLES  = `SFC_US_TO_CYCLES(`SFC_SECTOR_ERASE_TIME_US),
    parameter BLOCK_CYCLES   = `SFC_US_TO_CYCLES(`SFC_BLOCK_ERASE_TIME_US),
    parameter CHIP_CYCLES    = `SFC_US_TO_CYCLES(`SFC_CHIP_ERASE_TIME_US)
) (
    input  wire                clock_in,
    input  wire                sys_rst_in,
    input  wire                cs_n_in,
    input  wire                sck_in,
    input  wire                si_in,
    input  wire                wp_n_in,
    input  wire                auto_inc_set_in,
    output reg                 so_out,
    output reg                 so_oe_n_out,
    output reg                 erase_req_out,
    output reg  [1:0]          erase_kind_out,
    output reg  [23:0]         erase_base_out,
    output reg                 erase_done_out,
    output wire [7:0]          status_out
);

    // ------------------------------------------------------------
    // pin synchronisers; stage one feeds stage two only
    // ------------------------------------------------------------
    reg [2:0] cs_sync_q;
    reg [2:0] sck_sync_q;
    reg [1:0] si_sync_q;
    reg [1:0] wp_sync_q;

    always @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cs_sync_q  <= 3'h7;
            sck_sync_q <= 3'h0;
            si_sync_q  <= 2'h0;
            wp_sync_q  <= 2'h3;
        end else begin
            cs_sync_q  <= {cs_sync_q[1:0], cs_n_in};
            sck_sync_q <= {sck_sync_q[1:0], sck_in};
            si_sync_q  <= {si_sync_q[0], si_in};
            wp_sync_q  <= {wp_sync_q[0], wp_n_in};
        end
    end

    wire cs_low  = ~cs_sync_q[1];
    wire cs_rise = cs_sync_q[1] & ~cs_sync_q[2];
    wire sck_up  = sck_sync_q[1] & ~sck_sync_q[2] & cs_low;
    wire sck_dn  = ~sck_sync_q[1] & sck_sync_q[2] & cs_low;
    wire si_bit  = si_sync_q[1];
    wire wp_high = wp_sync_q[1];

    // ------------------------------------------------------------
    // protection check
    // ------------------------------------------------------------
    // level n guards the top (64K << (n-1)) bytes, capped at the array
    function prot_hit;
        input [23:0] base;
        input [4:0]  span_shift;
        input [3:0]  level;
        reg   [31:0] limit;
        reg   [31:0] guard;
        reg   [31:0] top;
        begin
            top   = 32'h0000_0001 << ARRAY_AW;
            guard = 32'h0000_0001 << (`SFC_BLOCK64_SHIFT + level - 1);
            if (guard > top)
                guard = top;
            limit = top - guard;
            prot_hit = (level != 4'h0) &&
                       (({8'h00, base} + (32'h0000_0001 << span_shift))
                        > limit);
        end
    endfunction

    // ------------------------------------------------------------
    // frame shifter
    // ------------------------------------------------------------
    reg [5:0]  bcnt_q;
    reg [23:0] sh_q;
    reg [7:0]  op_q;
    reg [23:0] addr_q;
    reg [7:0]  wdata_q;
    // overlong frames wrap the counter; never let them execute
    reg        wrap_q;

    always @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            bcnt_q  <= 6'h00;
            sh_q    <= 24'h00_0000;
            op_q    <= 8'h00;
            addr_q  <= 24'h00_0000;
            wdata_q <= 8'h00;
            wrap_q  <= 1'b0;
        end else if (!cs_low) begin
            bcnt_q <= 6'h00;
            wrap_q <= 1'b0;
        end else if (sck_up) begin
            sh_q <= {sh_q[22:0], si_bit};
            if (bcnt_q == `SFC_LEN_WRAP_TOP) begin
                bcnt_q <= `SFC_LEN_WRAP_BACK;
                wrap_q <= 1'b1;
            end else
                bcnt_q <= bcnt_q + 6'd1;
            if (bcnt_q == `SFC_LEN_OPCODE - 6'd1)
                op_q <= {sh_q[6:0], si_bit};
            if (bcnt_q == `SFC_LEN_STATUS_WRITE - 6'd1)
                wdata_q <= {sh_q[6:0], si_bit};
            if (bcnt_q == `SFC_LEN_ADDRESS - 6'd1)
                addr_q <= {sh_q[22:0], si_bit}; // see R2
        end
    end

    // ------------------------------------------------------------
    // status state and execution on deselect
    // ------------------------------------------------------------
    reg             wel_q;
    reg             aai_q;
    reg             arm_q;
    reg             lock_q;
    reg [3:0]       level_q;
    reg             busy_q;
    reg [CNT_W-1:0] busy_cnt_q;

    wire is_sector = (op_q == `SFC_OP_SECTOR_ERASE);
    wire is_b32    = (op_q == `SFC_OP_BLOCK32_ERASE);
    wire is_b64    = (op_q == `SFC_OP_BLOCK64_ERASE);
    wire is_chip   = (op_q == `SFC_OP_CHIP_ERASE_A) ||
                     (op_q == `SFC_OP_CHIP_ERASE_B); // see R6
    wire len_op    = (bcnt_q == `SFC_LEN_OPCODE);
    wire len_wr    = (bcnt_q == `SFC_LEN_STATUS_WRITE);
    wire len_addr  = (bcnt_q == `SFC_LEN_ADDRESS);
    wire framed    = cs_rise && (bcnt_q != 6'h00) && !wrap_q; // see R10

    reg  [4:0]  span_shift;
    reg  [23:0] base_mask;
    always @* begin
        span_shift = `SFC_SECTOR_SHIFT;
        base_mask  = 24'hFF_F000; // see R1
        if (is_b32) begin
            span_shift = `SFC_BLOCK32_SHIFT;
            base_mask  = 24'hFF_8000; // see R4
        end else if (is_b64) begin
            span_shift = `SFC_BLOCK64_SHIFT;
            base_mask  = 24'hFF_0000; // see R5
        end
    end

    wire [23:0] erase_base = addr_q & base_mask;
    wire region_erase = framed && len_addr && (is_sector || is_b32 || is_b64);
    wire chip_erase   = framed && len_op && is_chip;
    // erases are refused while busy, without latch, or on protection
    wire erase_ok = wel_q && !busy_q; // see R8
    wire go_region = region_erase && erase_ok &&
                     !prot_hit(erase_base, span_shift, level_q); // see R3
    wire go_chip   = chip_erase && erase_ok &&
                     (level_q == 4'h0); // see R7

    wire do_write_enable_cmd = framed && len_op && (op_q == `SFC_OP_WRITE_ENABLE);
    wire do_write_disable_cmd = framed && len_op &&
                   (op_q == `SFC_OP_WRITE_DISABLE); // see R25
    wire do_arm  = framed && len_op &&
                   (op_q == `SFC_OP_STATUS_ARM); // see R26
    wire do_status_write_cmd = framed && len_wr && !busy_q &&
                   (op_q == `SFC_OP_STATUS_WRITE);
    wire status_write_cmd_allowed = arm_q || wel_q; // see R17
    wire status_write_cmd_locked  = !wp_high && lock_q; // see R19
    wire status_write_cmd_go      = do_status_write_cmd && status_write_cmd_allowed && !status_write_cmd_locked;

    always @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wel_q   <= 1'b0;
            aai_q   <= 1'b0;
            arm_q   <= 1'b0;
            lock_q  <= 1'b0;
            level_q <= 4'h0;
        end else begin
            // arming lasts for exactly one following command
            if (do_arm)
                arm_q <= 1'b1;
            else if (framed)
                arm_q <= 1'b0; // see R17
            if (do_write_enable_cmd && !busy_q)
                wel_q <= 1'b1; // see R13
            else if (do_write_disable_cmd)
                wel_q <= 1'b0; // see R15
            else if (go_region || go_chip)
                wel_q <= 1'b0;
            else if (status_write_cmd_go && !arm_q)
                wel_q <= 1'b0; // see R14
            if (auto_inc_set_in)
                aai_q <= 1'b1;
            else if (do_write_disable_cmd)
                aai_q <= 1'b0; // see R15
            if (status_write_cmd_go) begin
                level_q <= wdata_q[`SFC_ST_LEVEL_LO+3:`SFC_ST_LEVEL_LO];
                if (wp_high)
                    lock_q <= wdata_q[`SFC_ST_LOCK]; // see R21
                else
                    lock_q <= lock_q | wdata_q[`SFC_ST_LOCK]; // see R20
            end // see R18
        end
    end

    // ------------------------------------------------------------
    // self-timed erase sequencer
    // ------------------------------------------------------------
    // write disable never touches this counter, so work runs to the end
    reg [CNT_W-1:0] load_cycles;
    always @* begin
        load_cycles = BLOCK_CYCLES[CNT_W-1:0];
        if (go_chip)
            load_cycles = CHIP_CYCLES[CNT_W-1:0];
        else if (is_sector)
            load_cycles = SECTOR_CYCLES[CNT_W-1:0];
    end

    always @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            busy_q         <= 1'b0;
            busy_cnt_q     <= {CNT_W{1'b0}};
            erase_req_out  <= 1'b0;
            erase_kind_out <= `SFC_KIND_SECTOR;
            erase_base_out <= 24'h00_0000;
            erase_done_out <= 1'b0;
        end else begin
            erase_req_out  <= 1'b0;
            erase_done_out <= 1'b0;
            if (go_region || go_chip) begin
                busy_q        <= 1'b1; // see R11
                busy_cnt_q    <= load_cycles;
                erase_req_out <= 1'b1;
                if (go_chip) begin
                    erase_kind_out <= `SFC_KIND_CHIP;
                    erase_base_out <= 24'h00_0000;
                end else begin
                    erase_base_out <= erase_base;
                    if (is_sector)
                        erase_kind_out <= `SFC_KIND_SECTOR;
                    else if (is_b32)
                        erase_kind_out <= `SFC_KIND_BLOCK32;
                    else
                        erase_kind_out <= `SFC_KIND_BLOCK64;
                end
            end else if (busy_q) begin
                if (busy_cnt_q <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
                    busy_q         <= 1'b0; // see R16
                    erase_done_out <= 1'b1;
                end
                busy_cnt_q <= busy_cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // ------------------------------------------------------------
    // status byte and read-back stream
    // ------------------------------------------------------------
    wire [7:0] status_byte = {lock_q, aai_q, level_q, wel_q, busy_q};
    assign status_out = status_byte;

    wire is_stat  = (op_q == `SFC_OP_STATUS_READ);
    wire is_jedec = (op_q == `SFC_OP_JEDEC_ID);
    wire is_lgcy  = (op_q == `SFC_OP_LEGACY_ID_A) ||
                    (op_q == `SFC_OP_LEGACY_ID_B);

    // byte chosen for the bit about to be shifted
    reg [7:0] tx_byte;
    reg       tx_en;
    always @* begin
        tx_byte = 8'h00;
        tx_en   = 1'b0;
        if (bcnt_q >= `SFC_LEN_OPCODE) begin
            if (is_stat) begin
                tx_en   = 1'b1;
                tx_byte = status_byte; // see R12
            end else if (is_jedec) begin
                tx_en = 1'b1;
                case (bcnt_q[5:3])
                    3'd1:    tx_byte = `SFC_ID_MAKER; // see R22
                    3'd2:    tx_byte = `SFC_ID_TYPE;
                    3'd3:    tx_byte = `SFC_ID_CAPACITY;
                    default: tx_byte = 8'h00;
                endcase
            end else if (is_lgcy && bcnt_q >= `SFC_LEN_ADDRESS) begin
                tx_en = 1'b1;
                // address bit 0 picks the start byte; byte index parity flips it
                if (addr_q[0] ^ bcnt_q[3])
                    tx_byte = `SFC_ID_CAPACITY; // see R24
                else
                    tx_byte = `SFC_ID_MAKER; // see R23
            end
        end
    end

    always @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            so_out      <= 1'b0;
            so_oe_n_out <= 1'b1;
        end else if (!cs_low) begin
            so_out      <= 1'b0;
            so_oe_n_out <= 1'b1;
        end else if (sck_dn && tx_en) begin
            so_out      <= tx_byte[3'd7 - bcnt_q[2:0]];
            so_oe_n_out <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ===== test/sfc_cmd_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------
// erase and status port checks
// ------------------------------------------
module sfc_cmd_assertions (
    input wire logic        clock_in,
    input wire logic        sys_rst_in,
    input wire logic        cs_n_in,
    input wire logic        wp_n_in,
    input wire logic        so_oe_n_out,
    input wire logic        erase_req_out,
    input wire logic [1:0]  erase_kind_out,
    input wire logic [23:0] erase_base_out,
    input wire logic        erase_done_out,
    input wire logic [7:0]  status_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    chk_req_pulse: assert property (
        erase_req_out |=> !erase_req_out) else $error("request too long");
    chk_req_busy: assert property (
        erase_req_out |-> $rose(status_out[0])) else $error("busy not raised");
    chk_busy_span: assert property (
        $rose(status_out[0]) |-> status_out[0] [*8])
        else $error("busy dropped early");
    chk_done_drop: assert property (
        erase_done_out |-> ##[0:1] !status_out[0])
        else $error("busy after done");
    chk_req_latch: assert property (
        erase_req_out |-> $past(status_out[1], 3))
        else $error("erase without latch");
    chk_req_deselect: assert property (
        erase_req_out |-> cs_n_in && $past(cs_n_in, 2))
        else $error("erase before deselect");
    chk_latch_deselect: assert property (
        $rose(status_out[1]) |-> cs_n_in) else $error("latch set early");
    chk_chip_guard: assert property (
        erase_req_out && erase_kind_out == 2'h3 |-> status_out[5:2] == 4'h0)
        else $error("chip erase while protected");
    chk_busy_hold: assert property (
        status_out[0] && !erase_req_out |->
        $stable(erase_kind_out) && $stable(erase_base_out))
        else $error("target moved while busy");
    chk_lock_pin: assert property (
        $fell(status_out[7]) |-> $past(wp_n_in, 3))
        else $error("lock cleared with pin low");
    chk_so_idle: assert property (
        cs_n_in [*6] |-> so_oe_n_out) else $error("output driven idle");
endmodule

bind sfc_cmd sfc_cmd_assertions chk (
    .clock_in       (clock_in),
    .sys_rst_in     (sys_rst_in),
    .cs_n_in        (cs_n_in),
    .wp_n_in        (wp_n_in),
    .so_oe_n_out    (so_oe_n_out),
    .erase_req_out  (erase_req_out),
    .erase_kind_out (erase_kind_out),
    .erase_base_out (erase_base_out),
    .erase_done_out (erase_done_out),
    .status_out     (status_out)
);
`default_nettype wire

// ===== test/sfc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------
// host side serial master, mode 0
// ------------------------------------------
module sfc_host_model (
    input  wire logic clock_in,
    input  wire logic so_in,
    input  wire logic so_oe_n_in,
    output var logic  cs_n_out,
    output var logic  sck_out,
    output var logic  si_out
);
    logic last_so = 1'b0;
    initial begin
        cs_n_out = 1'b1;
        sck_out = 1'b0;
        si_out = 1'b0;
    end
    // sck idles low between frames; released so reads as inverted last bit
    task automatic xfer(input logic [47:0] tx, input int nb, input int rb,
                        output logic [47:0] rx);
        rx = '0;
        @(negedge clock_in);
        cs_n_out = 1'b0;
        for (int i = 0; i < nb + rb; i++) begin
            si_out = (i < nb) ? tx[nb - 1 - i] : ~si_out;
            repeat (4) @(negedge clock_in);
            sck_out = 1'b1;
            last_so = so_oe_n_in ? ~last_so : so_in;
            rx = {rx[46:0], last_so};
            repeat (4) @(negedge clock_in);
            sck_out = 1'b0;
        end
        repeat (4) @(negedge clock_in);
        cs_n_out = 1'b1;
        si_out = ~si_out;
        repeat (8) @(negedge clock_in);
    endtask
endmodule
`default_nettype wire

// ===== test/sfc_cmd_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfc_defines.vh"
`define SFC_CHK(g, e) begin \
    check_count++; \
    if ((g) !== (e)) begin \
        fails++; \
        $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
end
module sfc_cmd_tb;
    typedef struct {logic [47:0] tx; int nb; int rb; logic [47:0] ex;} sfc_row_t;
    logic        clock_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic        wp_n_in = 1'b1;
    logic        auto_inc_set_in = 1'b0;
    wire logic   cs_n, sck, si, so_out, so_oe_n_out;
    wire logic   erase_req_out, erase_done_out;
    wire logic [1:0]  erase_kind_out;
    wire logic [23:0] erase_base_out;
    wire logic [7:0]  status_out;
    logic [47:0] rx;
    int          fails = 0;
    int          check_count = 0;
    int          req_count = 0;
    int          done_count = 0;
    sfc_row_t    rows [4];
    logic [7:0]  ops [5];
    logic [1:0]  kinds [5];
    int          sh [5];
    logic [23:0] addr = 24'hAB_CDEF;

    always #12.5 clock_in = ~clock_in;
    always @(posedge clock_in) if (erase_req_out === 1'b1) req_count++;
    always @(posedge clock_in) if (erase_done_out === 1'b1) done_count++;

    sfc_cmd #(.SECTOR_CYCLES(400), .BLOCK_CYCLES(400), .CHIP_CYCLES(500)) dut (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in), .cs_n_in(cs_n),
        .sck_in(sck), .si_in(si), .wp_n_in(wp_n_in),
        .auto_inc_set_in(auto_inc_set_in), .so_out(so_out),
        .so_oe_n_out(so_oe_n_out), .erase_req_out(erase_req_out),
        .erase_kind_out(erase_kind_out), .erase_base_out(erase_base_out),
        .erase_done_out(erase_done_out), .status_out(status_out));
    sfc_host_model host (.clock_in(clock_in), .so_in(so_out),
        .so_oe_n_in(so_oe_n_out), .cs_n_out(cs_n), .sck_out(sck), .si_out(si));

    // ------------------------------------------
    // helpers
    // ------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic cmd8(input logic [7:0] op);
        host.xfer({40'h0, op}, 8, 0, rx);
    endtask
    task automatic sts_wr(input logic [7:0] pre, input logic [7:0] d);
        cmd8(pre);
        host.xfer({32'h0, `SFC_OP_STATUS_WRITE, d}, 16, 0, rx);
    endtask
    task automatic erase(input logic [7:0] op, input int nb);
        if (nb == 8) host.xfer({40'h0, op}, 8, 0, rx);
        else host.xfer({16'h0, op, addr}, 32, 0, rx);
    endtask
    // bounded: a hung erase must not stall the run
    task automatic wait_done();
        int n = 0;
        while (status_out[0] !== 1'b0 && n < 1000) begin
            @(negedge clock_in);
            n++;
        end
        if (n == 1000) begin
            `SFC_CHK(status_out[0], 1'b0)
            finish_test();
        end
    endtask

    // ------------------------------------------
    // main sequence
    // ------------------------------------------
    initial begin
        rows[0] = '{{40'h0, `SFC_OP_JEDEC_ID}, 8, 32, {16'h0, `SFC_ID_MAKER,
                    `SFC_ID_TYPE, `SFC_ID_CAPACITY, 8'h00}};
        rows[1] = '{{16'h0, `SFC_OP_LEGACY_ID_A, 24'h00_0000}, 32, 24,
                    {24'h0, `SFC_ID_MAKER, `SFC_ID_CAPACITY, `SFC_ID_MAKER}};
        rows[2] = '{{16'h0, `SFC_OP_LEGACY_ID_B, 24'h00_0001}, 32, 16,
                    {32'h0, `SFC_ID_CAPACITY, `SFC_ID_MAKER}};
        rows[3] = '{{40'h0, `SFC_OP_STATUS_READ}, 8, 16, 48'h0};
        ops = '{`SFC_OP_SECTOR_ERASE, `SFC_OP_BLOCK32_ERASE,
                `SFC_OP_BLOCK64_ERASE, `SFC_OP_CHIP_ERASE_A, `SFC_OP_CHIP_ERASE_B};
        kinds = '{`SFC_KIND_SECTOR, `SFC_KIND_BLOCK32, `SFC_KIND_BLOCK64,
                  `SFC_KIND_CHIP, `SFC_KIND_CHIP};
        sh = '{`SFC_SECTOR_SHIFT, `SFC_BLOCK32_SHIFT, `SFC_BLOCK64_SHIFT, 0, 0};
        repeat (16) @(negedge clock_in);
        sys_rst_in = 1'b0;
        repeat (4) @(negedge clock_in);
        for (int r = 0; r < 4; r++) begin
            host.xfer(rows[r].tx, rows[r].nb, rows[r].rb, rx);
            `SFC_CHK(rx & ((48'h1 << rows[r].rb) - 48'h1), rows[r].ex)
        end
        $display("id and status reads done");
        erase(`SFC_OP_SECTOR_ERASE, 32);
        `SFC_CHK(req_count, 0)
        host.xfer({39'h0, `SFC_OP_WRITE_ENABLE, 1'b0}, 9, 0, rx);
        `SFC_CHK(status_out, 8'h00)
        cmd8(`SFC_OP_WRITE_ENABLE);
        `SFC_CHK(status_out, 8'h02)
        for (int k = 0; k < 5; k++) begin
            if (k > 0) cmd8(`SFC_OP_WRITE_ENABLE);
            erase(ops[k], (k < 3) ? 32 : 8);
            `SFC_CHK(req_count, k + 1)
            `SFC_CHK(erase_kind_out, kinds[k])
            if (k < 3) `SFC_CHK(erase_base_out, addr & ~((24'h1 << sh[k]) - 24'h1))
            host.xfer({40'h0, `SFC_OP_STATUS_READ}, 8, 8, rx);
            `SFC_CHK(rx[0], 1'b1)
            if (k == 0) cmd8(`SFC_OP_WRITE_DISABLE);
            if (k == 0) `SFC_CHK(status_out[0], 1'b1)
            wait_done();
            `SFC_CHK(status_out[1:0], 2'h0)
        end
        $display("erase kinds done");
        sts_wr(`SFC_OP_STATUS_ARM, 8'hFF);
        `SFC_CHK(status_out, 8'hBC)
        cmd8(`SFC_OP_WRITE_ENABLE);
        erase(`SFC_OP_CHIP_ERASE_B, 8);
        erase(`SFC_OP_SECTOR_ERASE, 32);
        `SFC_CHK(req_count, 5)
        `SFC_CHK(done_count, 5)
        cmd8(`SFC_OP_WRITE_DISABLE);
        `SFC_CHK(status_out, 8'hBC)
        wp_n_in = 1'b0;
        sts_wr(`SFC_OP_STATUS_ARM, 8'h00);
        `SFC_CHK(status_out, 8'hBC)
        wp_n_in = 1'b1;
        cmd8(`SFC_OP_WRITE_ENABLE);
        sts_wr(`SFC_OP_STATUS_ARM, 8'h00);
        `SFC_CHK(status_out, 8'h02)
        sts_wr(`SFC_OP_WRITE_ENABLE, 8'h04);
        `SFC_CHK(status_out, 8'h04)
        wp_n_in = 1'b0;
        sts_wr(`SFC_OP_STATUS_ARM, 8'h80);
        `SFC_CHK(status_out, 8'h80)
        wp_n_in = 1'b1;
        sts_wr(`SFC_OP_STATUS_ARM, 8'h00);
        cmd8(`SFC_OP_STATUS_ARM);
        host.xfer({40'h0, `SFC_OP_STATUS_READ}, 8, 8, rx);
        host.xfer({32'h0, `SFC_OP_STATUS_WRITE, 8'h08}, 16, 0, rx);
        `SFC_CHK(status_out, 8'h00)
        $display("status write paths done");
        auto_inc_set_in = 1'b1;
        @(negedge clock_in);
        auto_inc_set_in = 1'b0;
        cmd8(`SFC_OP_WRITE_ENABLE);
        `SFC_CHK(status_out, 8'h42)
        cmd8(`SFC_OP_WRITE_DISABLE);
        `SFC_CHK(status_out, 8'h00)
        cmd8(`SFC_OP_WRITE_ENABLE);
        sys_rst_in = 1'b1;
        repeat (2) @(negedge clock_in);
        `SFC_CHK(status_out, 8'h00)
        sys_rst_in = 1'b0;
        repeat (4) @(negedge clock_in);
        $display("disable and reset done");
        finish_test();
    end
endmodule
`default_nettype wire
